// *** tb/spss_host.sv ***
// Power controller model: rails and shutdown pin sequencing
`timescale 1ns/1ps
module spss_host #(
    parameter HOLD = 10000
) (
    input wire clk_i,
    input wire up_i,
    output wire io_ok_o,
    output wire core_ok_o,
    output wire analog_ok_o,
    output wire shdn_n_o
);
    reg [15:0] step_r = 16'h0000;
    // One ramp both ways, so power-down is the exact reverse of power-up
    always @(posedge clk_i)
        if (up_i && step_r < HOLD + 2003)
            step_r <= step_r + 16'h0001;
        else if (!up_i && step_r != 16'h0000)
            step_r <= step_r - 16'h0001;
    assign io_ok_o = step_r > 0;
    assign core_ok_o = step_r > 2000;
    assign analog_ok_o = step_r > 2002;
    assign shdn_n_o = step_r > HOLD + 2002;
endmodule

// *** tb/spss_properties.sv ***
// Port assertions of the sensor power state sequencer
`timescale 1ns/1ps
module spss_props #(
    parameter PLL_LOCK_CYC = 10000
) (
    input wire CLK_I,
    input wire RST_N_I,
    input wire SHUTDOWN_N_PIN_I,
    input wire IO_RAIL_OK_I,
    input wire CORE_RAIL_OK_I,
    input wire ANALOG_RAIL_OK_I,
    input wire REG_RD_I,
    input wire [15:0] REG_RDATA_O,
    input wire REG_READY_O,
    input wire [1:0] STATE_O,
    input wire OUTPUT_EN_O,
    input wire DIGITAL_PWR_EN_O,
    input wire PLL_LOCKED_O
);
    wire pwr = SHUTDOWN_N_PIN_I & IO_RAIL_OK_I & CORE_RAIL_OK_I & ANALOG_RAIL_OK_I;
    reg [15:0] up_r;
    // ====================
    // Powered cycle count, saturating so it cannot wrap into a false pass
    always @(posedge CLK_I or negedge RST_N_I)
        if (!RST_N_I)
            up_r <= 16'h0000;
        else if (!DIGITAL_PWR_EN_O)
            up_r <= 16'h0000;
        else if (up_r != 16'hFFFF)
            up_r <= up_r + 16'h0001;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ====================
    // Properties
    one_state_a: assert property (STATE_O != 2'h3) else $error("bad state");
    pwr_off_a: assert property (!pwr |=> !DIGITAL_PWR_EN_O) else $error("power on");
    hard_stby_a: assert property (!SHUTDOWN_N_PIN_I |=> STATE_O == 2'h0 && !OUTPUT_EN_O && !REG_READY_O) else $error("no standby");
    stream_lock_a: assert property (STATE_O == 2'h2 |-> PLL_LOCKED_O) else $error("unlocked");
    init_len_a: assert property ($rose(REG_READY_O) && $past(STATE_O) == 2'h0 |-> up_r >= 16'h095F) else $error("init short");
    lock_len_a: assert property ($rose(PLL_LOCKED_O) |-> up_r >= PLL_LOCK_CYC - 1) else $error("lock short");
    ready_state_a: assert property (REG_READY_O |-> STATE_O != 2'h0 && DIGITAL_PWR_EN_O) else $error("early ready");
    rdata_hold_a: assert property ((!REG_RD_I && pwr) [*2] |-> $stable(REG_RDATA_O)) else $error("data moved");
    soft_quiet_a: assert property (STATE_O == 2'h1 |-> !OUTPUT_EN_O) else $error("output on");
endmodule

bind spss_top spss_props #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) u_props (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .SHUTDOWN_N_PIN_I(SHUTDOWN_N_PIN_I),
    .IO_RAIL_OK_I(IO_RAIL_OK_I),
    .CORE_RAIL_OK_I(CORE_RAIL_OK_I),
    .ANALOG_RAIL_OK_I(ANALOG_RAIL_OK_I),
    .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O),
    .REG_READY_O(REG_READY_O),
    .STATE_O(STATE_O),
    .OUTPUT_EN_O(OUTPUT_EN_O),
    .DIGITAL_PWR_EN_O(DIGITAL_PWR_EN_O),
    .PLL_LOCKED_O(PLL_LOCKED_O)
);

// *** tb/spss_top_tb.sv ***
// Self-checking bench of the sensor power state sequencer
`timescale 1ns/1ps
`include "spss_defines.vh"
module spss_top_tb;
    reg CLK_I = 1'b0;
    reg RST_N_I = 1'b0;
    reg up = 1'b0;
    reg ROW_END_I = 1'b0;
    reg FRAME_END_I = 1'b0;
    reg REG_WR_I = 1'b0;
    reg REG_RD_I = 1'b0;
    reg [15:0] REG_ADDR_I = 16'h0000;
    reg [15:0] REG_WDATA_I = 16'h0000;
    reg [15:0] v;
    reg rd_seen = 1'b0;
    reg [15:0] exp_q [$];
    wire [15:0] REG_RDATA_O;
    wire [1:0] STATE_O;
    wire REG_READY_O, OUTPUT_EN_O, DIGITAL_PWR_EN_O, PLL_LOCKED_O, pin, io, core, ana;
    wire [15:0] stat = {11'h000, DIGITAL_PWR_EN_O, STATE_O, OUTPUT_EN_O, REG_READY_O};
    integer fails = 0;
    integer comparisons = 0;
    integer cyc = 0;
    integer n;
    integer m;
    spss_host u_host (.clk_i(CLK_I), .up_i(up), .io_ok_o(io), .core_ok_o(core), .analog_ok_o(ana), .shdn_n_o(pin));
    spss_top #(.PLL_LOCK_CYC(3000)) DUT (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .SHUTDOWN_N_PIN_I(pin),
        .IO_RAIL_OK_I(io), .CORE_RAIL_OK_I(core), .ANALOG_RAIL_OK_I(ana), .ROW_END_I(ROW_END_I),
        .FRAME_END_I(FRAME_END_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
        .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_READY_O(REG_READY_O), .STATE_O(STATE_O),
        .OUTPUT_EN_O(OUTPUT_EN_O), .DIGITAL_PWR_EN_O(DIGITAL_PWR_EN_O), .PLL_LOCKED_O(PLL_LOCKED_O));
    // ====================
    // Tasks
    function [15:0] st(input [1:0] s, input [2:0] f);
        st = {11'h000, f[2], s, f[1:0]};
    endfunction
    task test_done;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp)
            begin
                fails = fails + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick;
        begin
            @(posedge CLK_I);
            #1;
        end
    endtask
    task wr(input [15:0] a, input [15:0] d);
        begin
            REG_ADDR_I = a;
            REG_WDATA_I = d;
            REG_WR_I = 1'b1;
            tick;
            REG_WR_I = 1'b0;
            tick;
        end
    endtask
    task rd(input [15:0] a, input [15:0] e);
        begin
            exp_q.push_back(e);
            REG_ADDR_I = a;
            REG_RD_I = 1'b1;
            tick;
            REG_RD_I = 1'b0;
            tick;
        end
    endtask
    task pulse(input f);
        begin
            ROW_END_I = !f;
            FRAME_END_I = f;
            tick;
            ROW_END_I = 1'b0;
            FRAME_END_I = 1'b0;
            repeat (2) tick;
        end
    endtask
    // ====================
    // Read data is judged half a cycle after the strobe is taken
    always @(posedge CLK_I)
        rd_seen <= REG_RD_I;
    always @(negedge CLK_I)
        if (rd_seen)
            chk(REG_RDATA_O, exp_q.pop_front());
    always @(posedge CLK_I)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            fails = fails + 1;
            test_done;
        end
    end
    initial
        forever #50 CLK_I = ~CLK_I;
    // ====================
    // Main sequence
    initial
    begin
        void'($urandom(2926));
        repeat (5) @(posedge CLK_I);
        #1 RST_N_I = 1'b1;
        chk(stat, st(0, 3'b000));
        up = 1'b1;
        while (DIGITAL_PWR_EN_O !== 1'b1) tick;
        chk(stat, st(0, 3'b100));
        n = 0;
        while (REG_READY_O !== 1'b1)
        begin
            tick;
            n = n + 1;
        end
        chk(n[15:0], 16'h0961);
        chk(stat, st(1, 3'b101));
        rd(`SPSS_REG_RUN_CTRL, `SPSS_RUN_CTRL_RESET);
        rd(16'h1234, `SPSS_UNMAPPED_DATA);
        for (m = 0; m < 2; m = m + 1)
        begin
            v = ($urandom & 16'hFFEB) | {11'h000, m[0], 4'h0};
            wr(`SPSS_REG_RUN_CTRL, v | 16'h0004);
            if (m == 0)
                chk(stat, st(1, 3'b101));
            while (PLL_LOCKED_O !== 1'b1) tick;
            repeat (3) tick;
            chk(stat, st(2, 3'b111));
            wr(`SPSS_REG_RUN_CTRL, v);
            pulse(!m[0]);
            chk(stat, st(2, 3'b111));
            pulse(m[0]);
            chk(stat, st(1, 3'b101));
            rd(`SPSS_REG_RUN_CTRL, v);
        end
        wr(`SPSS_REG_REINIT, 16'h0001);
        chk(stat, st(1, 3'b100));
        n = 0;
        while (REG_READY_O !== 1'b1)
        begin
            tick;
            n = n + 1;
        end
        chk(n[15:0], 16'h0960);
        chk(stat, st(1, 3'b101));
        // The reference clock is the only clock here, so its stop is kept as a 100 us quiet gap
        repeat (1000) tick;
        up = 1'b0;
        repeat (3) tick;
        chk(stat, st(0, 3'b000));
        while (io !== 1'b0) tick;
        up = 1'b1;
        while (REG_READY_O !== 1'b1) tick;
        rd(`SPSS_REG_RUN_CTRL, `SPSS_RUN_CTRL_RESET);
        test_done;
    end
endmodule

// *** verilog/spss_cnt.v ***
// One-shot cycle counter with load, abort and done pulse
`timescale 1ns/1ps

module spss_cnt #(
    parameter W = 16
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire start_i,
    input wire abort_i,
    input wire [W-1:0] load_i,
    output reg busy_o,
    output reg done_o
);

reg [W-1:0] count_r;

always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        count_r <= {W{1'b0}};
        busy_o <= 1'b0;
        done_o <= 1'b0;
    end
    else if (abort_i)
    begin
        count_r <= {W{1'b0}};
        busy_o <= 1'b0;
        done_o <= 1'b0;
    end
    else if (start_i)
    begin
        // Loaded with N-1 so done fires N cycles after start
        count_r <= load_i - {{(W-1){1'b0}}, 1'b1};
        busy_o <= 1'b1;
        done_o <= 1'b0;
    end
    else if (busy_o && count_r == {W{1'b0}})
    begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
    end
    else
    begin
        if (busy_o)
        begin
            count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
        end
        done_o <= 1'b0;
    end
end

endmodule

// *** verilog/spss_defines.vh ***
// Constants for the sensor power state sequencer
`ifndef SPSS_DEFINES_VH
`define SPSS_DEFINES_VH

// ============================================================
// Register offsets and fields
`define SPSS_REG_RUN_CTRL 16'h301A
`define SPSS_REG_REINIT 16'h3021
`define SPSS_RUN_CTRL_RESET 16'h0000
`define SPSS_RUN_STREAM_BIT 2
`define SPSS_RUN_FRAME_BIT 4
`define SPSS_REINIT_BIT 0
`define SPSS_UNMAPPED_DATA 16'h0000

// ============================================================
// Externally visible state codes
`define SPSS_ST_HARD_STBY 2'h0
`define SPSS_ST_SOFT_STBY 2'h1
`define SPSS_ST_STREAMING 2'h2

// ============================================================
// Timing: the clock is the reference clock
`define SPSS_CLK_KHZ 10000
`define SPSS_INIT_REF_CYCLES 16'h0960
`define SPSS_INIT_CYC (`SPSS_INIT_REF_CYCLES)
`define SPSS_PLL_LOCK_MS 1
`define SPSS_PLL_LOCK_CYC (`SPSS_PLL_LOCK_MS * `SPSS_CLK_KHZ)
`define SPSS_CNT_W 16

`endif

// *** verilog/spss_top.v ***
// Power, reset and operating-state sequencer of the camera sensor
`timescale 1ns/1ps
`include "spss_defines.vh"

module spss_top #(
    parameter PLL_LOCK_CYC = `SPSS_PLL_LOCK_CYC
) (
    input wire CLK_I,
    input wire RST_N_I,
    input wire SHUTDOWN_N_PIN_I,
    input wire IO_RAIL_OK_I,
    input wire CORE_RAIL_OK_I,
    input wire ANALOG_RAIL_OK_I,
    input wire ROW_END_I,
    input wire FRAME_END_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [15:0] REG_ADDR_I,
    input wire [15:0] REG_WDATA_I,
    output reg [15:0] REG_RDATA_O,
    output reg REG_READY_O,
    output reg [1:0] STATE_O,
    output reg OUTPUT_EN_O,
    output reg DIGITAL_PWR_EN_O,
    output reg PLL_LOCKED_O
);

// ============================================================
// Internal states
localparam S_HARD = 3'h0;
localparam S_INIT = 3'h1;
localparam S_SOFT = 3'h2;
localparam S_STREAM = 3'h3;
localparam S_STOP = 3'h4;

localparam [`SPSS_CNT_W-1:0] INIT_LOAD = `SPSS_INIT_CYC;
// Lock count must fit the counter width; upper bits are dropped on purpose
localparam [`SPSS_CNT_W-1:0] PLL_LOAD = PLL_LOCK_CYC[`SPSS_CNT_W-1:0];

// ============================================================
// Reset release
reg rst_meta_r;
reg rst_sync_r;

always @(posedge CLK_I or negedge RST_N_I)
begin
    if (!RST_N_I)
    begin
        rst_meta_r <= 1'b0;
        rst_sync_r <= 1'b0;
    end
    else
    begin
        rst_meta_r <= 1'b1;
        rst_sync_r <= rst_meta_r;
    end
end

// ============================================================
// Power condition and sequencing
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [15:0] run_ctrl_r;
reg pll_locked_r;
wire init_done;
wire pll_done;
wire init_busy;
wire rails_ok;
wire powered;
wire hard_start;
wire acc_ok;
wire wr_run;
wire wr_reinit;
wire boundary;

assign rails_ok = IO_RAIL_OK_I & CORE_RAIL_OK_I & ANALOG_RAIL_OK_I;
// Pin low or a missing rail forces the sensor reset
assign powered = rails_ok & SHUTDOWN_N_PIN_I;
assign hard_start = (state_r == S_HARD) & powered;
// Registers are only reachable once initialization is over
assign acc_ok = powered & (state_r == S_SOFT || state_r == S_STREAM || state_r == S_STOP);
assign wr_run = acc_ok & REG_WR_I & (REG_ADDR_I == `SPSS_REG_RUN_CTRL);
// Reinit only honoured from soft standby
assign wr_reinit = powered & (state_r == S_SOFT) & REG_WR_I & (REG_ADDR_I == `SPSS_REG_REINIT)
    & REG_WDATA_I[`SPSS_REINIT_BIT];
// Boundary chosen by the frame select bit
assign boundary = run_ctrl_r[`SPSS_RUN_FRAME_BIT] ? FRAME_END_I : ROW_END_I;

spss_cnt #(
    .W(`SPSS_CNT_W)
) u_init_cnt (
    .clk_i(CLK_I),
    .rst_n_i(rst_sync_r),
    .start_i(hard_start | wr_reinit),
    .abort_i(~powered),
    .load_i(INIT_LOAD),
    .busy_o(init_busy),
    .done_o(init_done)
);

spss_cnt #(
    .W(`SPSS_CNT_W)
) u_pll_cnt (
    .clk_i(CLK_I),
    .rst_n_i(rst_sync_r),
    .start_i(hard_start),
    .abort_i(~powered),
    .load_i(PLL_LOAD),
    .busy_o(),
    .done_o(pll_done)
);

// ============================================================
// State machine
always @*
begin
    state_nxt = state_r;
    case (state_r)
        S_HARD:
        begin
            if (powered)
            begin
                state_nxt = S_INIT;
            end
        end
        S_INIT:
        begin
            if (init_done)
            begin
                state_nxt = S_SOFT;
            end
        end
        S_SOFT:
        begin
            if (wr_reinit)
            begin
                state_nxt = S_INIT;
            end
            else if (run_ctrl_r[`SPSS_RUN_STREAM_BIT] && pll_locked_r)
            begin
                state_nxt = S_STREAM;
            end
        end
        S_STREAM:
        begin
            if (!run_ctrl_r[`SPSS_RUN_STREAM_BIT])
            begin
                state_nxt = S_STOP;
            end
        end
        S_STOP:
        begin
            if (boundary)
            begin
                state_nxt = S_SOFT;
            end
        end
        default:
        begin
            state_nxt = S_HARD;
        end
    endcase
    // Held in hard standby as long as the pin stays low or a rail is missing
    if (!powered)
    begin
        state_nxt = S_HARD;
    end
end

always @(posedge CLK_I or negedge rst_sync_r)
begin
    if (!rst_sync_r)
    begin
        state_r <= S_HARD;
        run_ctrl_r <= `SPSS_RUN_CTRL_RESET;
        pll_locked_r <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        if (!powered)
        begin
            // Contents lost, defaults back after the hard reset
            run_ctrl_r <= `SPSS_RUN_CTRL_RESET;
            pll_locked_r <= 1'b0;
        end
        else
        begin
            // Soft standby and reinit leave registers alone
            if (wr_run)
            begin
                run_ctrl_r <= REG_WDATA_I;
            end
            if (pll_done)
            begin
                pll_locked_r <= 1'b1;
            end
        end
    end
end

// ============================================================
// Registered outputs
always @(posedge CLK_I or negedge rst_sync_r)
begin
    if (!rst_sync_r)
    begin
        STATE_O <= `SPSS_ST_HARD_STBY;
        OUTPUT_EN_O <= 1'b0;
        DIGITAL_PWR_EN_O <= 1'b0;
        PLL_LOCKED_O <= 1'b0;
        REG_READY_O <= 1'b0;
        REG_RDATA_O <= `SPSS_UNMAPPED_DATA;
    end
    else
    begin
        // Reinit from soft standby still reports soft standby
        case (state_nxt)
            S_SOFT:
            begin
                STATE_O <= `SPSS_ST_SOFT_STBY;
            end
            S_STREAM, S_STOP:
            begin
                STATE_O <= `SPSS_ST_STREAMING;
            end
            S_INIT:
            begin
                STATE_O <= (state_r == S_SOFT || STATE_O == `SPSS_ST_SOFT_STBY) ?
                    `SPSS_ST_SOFT_STBY : `SPSS_ST_HARD_STBY;
            end
            default:
            begin
                STATE_O <= `SPSS_ST_HARD_STBY;
            end
        endcase
        // Output runs until the boundary ends the stop
        OUTPUT_EN_O <= (state_nxt == S_STREAM) || (state_nxt == S_STOP);
        DIGITAL_PWR_EN_O <= powered;
        PLL_LOCKED_O <= powered & (pll_locked_r | pll_done);
        REG_READY_O <= powered & (state_nxt == S_SOFT || state_nxt == S_STREAM || state_nxt == S_STOP);
        if (REG_RD_I)
        begin
            if (acc_ok && REG_ADDR_I == `SPSS_REG_RUN_CTRL)
            begin
                REG_RDATA_O <= run_ctrl_r;
            end
            else if (acc_ok && REG_ADDR_I == `SPSS_REG_REINIT)
            begin
                REG_RDATA_O <= {15'h0000, init_busy};
            end
            else
            begin
                REG_RDATA_O <= `SPSS_UNMAPPED_DATA;
            end
        end
    end
end

endmodule
